/* core/ksrm_regs.sv */
// keyed system register bank with apb slave and write-protection logic
//
// Contract
// - calendar registers locked after power-on reset
// - key write of unlock code enables writes
// - timer, pll, reset-status refuse writes when locked
// - system clock control accepts one write
// - multiply-factor lock protects pll multiply field
// - low-power lock protects clock source, mode
// - checkstop reset enable written once per soft reset
// - whole-register lock bit makes register read-only
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ksrm_regs
(
	// clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hard_reset,
	input wire logic soft_reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic [ksrm_pkg::KSRM_AW-1:0] paddr,
	input wire logic pwrite,
	input wire logic [ksrm_pkg::KSRM_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [ksrm_pkg::KSRM_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer value shown read-only
	input wire logic [15:0] pit_value,
	// configuration to the clock and timer logic
	output logic [11:0] pll_multiply_factor,
	output logic clock_source_select,
	output logic [1:0] low_power_mode_select,
	output logic checkstop_reset_enable,
	output logic tb_write_lock
);

	logic [31:0] regs_r [ksrm_pkg::KSRM_NREG];
	logic [ksrm_pkg::KSRM_NKEY-1:0] key_lock_r;
	logic sys_clk_done_r;
	logic csr_done_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	ksrm_pkg::ksrm_dec_t dec;
	logic reg_locked;
	logic [31:0] byte_mask;
	logic [31:0] wmask;
	logic wr_go;
	logic key_ok;
	logic setup_ph;
	logic access_ph;

	function automatic ksrm_pkg::ksrm_dec_t ksrm_decode(input logic [23:0] a);
		ksrm_pkg::ksrm_dec_t d;
		d = '0;
		for (int i = 0; i < ksrm_pkg::KSRM_NREG; i++)
		begin
			if (a == ksrm_pkg::KSRM_REG_OFS[i])
			begin
				d.hit = 1'b1;
				d.idx = i[4:0];
			end
		end
		for (int k = 0; k < ksrm_pkg::KSRM_NKEY; k++)
		begin
			if (a == ksrm_pkg::KSRM_KEY_OFS[k])
			begin
				d.hit = 1'b1;
				d.is_key = 1'b1;
				d.kidx = k[3:0];
			end
		end
		return d;
	endfunction : ksrm_decode

	// byte strobes widened to a bit mask
	function automatic logic [31:0] ksrm_lane_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++)
		begin
			m[b*8 +: 8] = {8{s[b]}};
		end
		return m;
	endfunction : ksrm_lane_mask

	// bits of the pll register held by the clock-control locks and the once flag
	function automatic logic [31:0] ksrm_pll_guard(input logic [31:0] sys_clk,
		input logic csr_done);
		logic [31:0] g;
		g = '0;
		if (sys_clk[ksrm_pkg::KSRM_MFL_BIT])
		begin
			g[ksrm_pkg::KSRM_MF_HI:ksrm_pkg::KSRM_MF_LO] = '1;
		end
		if (sys_clk[ksrm_pkg::KSRM_LOW_POWER_MODE_LOCK_BIT])
		begin
			g[ksrm_pkg::KSRM_CLOCK_SOURCE_SELECT_BIT] = 1'b1;
			g[ksrm_pkg::KSRM_LPM_HI:ksrm_pkg::KSRM_LPM_LO] = '1;
		end
		if (csr_done)
		begin
			g[ksrm_pkg::KSRM_CSR_BIT] = 1'b1;
		end
		return g;
	endfunction : ksrm_pll_guard

	// read view of one location; writes and misses read zero
	function automatic logic [31:0] ksrm_read_word(input ksrm_pkg::ksrm_dec_t d,
		input logic is_write,
		input logic [31:0] stored,
		input logic [ksrm_pkg::KSRM_NKEY-1:0] locks,
		input logic [15:0] pit);
		logic [31:0] w;
		w = '0;
		if (!d.hit || is_write)
		begin
			w = '0;
		end
		else if (d.is_key)
		begin
			w[ksrm_pkg::KSRM_KEY_LOCK_BIT] = locks[d.kidx];
		end
		else if (d.idx == ksrm_pkg::KSRM_I_PIT_VAL)
		begin
			w[15:0] = pit;
		end
		else if (ksrm_pkg::KSRM_NARROW[d.idx])
		begin
			// upper half of a narrow register is reserved
			w = stored & ksrm_pkg::KSRM_MASK16;
		end
		else
		begin
			w = stored;
		end
		return w;
	endfunction : ksrm_read_word

	assign dec = ksrm_decode(paddr);
	assign setup_ph = psel & ~penable;
	// write completes at the access edge, address held stable by the master
	assign access_ph = psel & penable & pready_r;
	assign wr_go = access_ph & pwrite & dec.hit;
	assign key_ok = (pstrb == 4'hF) && (pwdata == ksrm_pkg::KSRM_UNLOCK_CODE);

	always_comb
	begin
		reg_locked = 1'b0;
		for (int k = 0; k < ksrm_pkg::KSRM_NKEY; k++)
		begin
			if (!dec.is_key && ksrm_pkg::KSRM_KEY_TGT[k] == dec.idx && key_lock_r[k])
			begin
				reg_locked = 1'b1;
			end
		end
	end

	always_comb
	begin
		byte_mask = ksrm_lane_mask(pstrb);
		wmask = byte_mask;
		if (ksrm_pkg::KSRM_NARROW[dec.idx])
		begin
			wmask = wmask & ksrm_pkg::KSRM_MASK16;
		end
		if (!dec.hit || dec.is_key || ksrm_pkg::KSRM_NOSTORE[dec.idx])
		begin
			wmask = '0;
		end
		if (reg_locked)
		begin
			wmask = '0;
		end
		if (dec.idx == ksrm_pkg::KSRM_I_SYS_CLK && sys_clk_done_r)
		begin
			wmask = '0;
		end
		if (dec.idx == ksrm_pkg::KSRM_I_PLL_LPR)
		begin
			wmask = wmask & ~ksrm_pll_guard(regs_r[ksrm_pkg::KSRM_I_SYS_CLK], csr_done_r);
		end
		if ((dec.idx == ksrm_pkg::KSRM_I_FA_MCFG || dec.idx == ksrm_pkg::KSRM_I_FB_MCFG) &&
			regs_r[dec.idx][ksrm_pkg::KSRM_DLK_BIT])
		begin
			wmask = '0;
		end
	end

	// data registers; hard reset clears only the hard-reset class
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < ksrm_pkg::KSRM_NREG; i++)
			begin
				regs_r[i] <= ksrm_pkg::KSRM_RST_VAL;
			end
		end
		else if (hard_reset)
		begin
			for (int i = 0; i < ksrm_pkg::KSRM_NREG; i++)
			begin
				if (ksrm_pkg::KSRM_HARD_CLR[i])
				begin
					regs_r[i] <= ksrm_pkg::KSRM_RST_VAL;
				end
			end
		end
		else if (wr_go && !dec.is_key)
		begin
			regs_r[dec.idx] <= (regs_r[dec.idx] & ~wmask) | (pwdata & wmask);
		end
	end

	// key locks survive hard and soft reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_lock_r <= ksrm_pkg::KSRM_KEY_POR_LOCK;
		end
		else if (wr_go && dec.is_key)
		begin
			key_lock_r[dec.kidx] <= !key_ok;
		end
	end

	// only an accepted write uses up the single write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sys_clk_done_r <= 1'b0;
		end
		else if (wr_go && !dec.is_key && dec.idx == ksrm_pkg::KSRM_I_SYS_CLK && wmask != '0)
		begin
			sys_clk_done_r <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			csr_done_r <= 1'b0;
		end
		else if (soft_reset || hard_reset)
		begin
			csr_done_r <= 1'b0;
		end
		else if (wr_go && !dec.is_key && dec.idx == ksrm_pkg::KSRM_I_PLL_LPR &&
			wmask[ksrm_pkg::KSRM_CSR_BIT])
		begin
			csr_done_r <= 1'b1;
		end
	end

	// zero-wait answer: ready follows every setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
		end
		else
		begin
			pready_r <= setup_ph;
		end
	end

	// misses are flagged rather than stalled, so a bad address never hangs the bus
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pslverr_r <= 1'b0;
		end
		else if (setup_ph)
		begin
			pslverr_r <= !dec.hit;
		end
	end

	// read data captured in setup and held until the next setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= '0;
		end
		else if (setup_ph)
		begin
			prdata_r <= ksrm_read_word(dec, pwrite, regs_r[dec.idx], key_lock_r, pit_value);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pll_multiply_factor = regs_r[ksrm_pkg::KSRM_I_PLL_LPR][ksrm_pkg::KSRM_MF_HI:ksrm_pkg::KSRM_MF_LO];
	assign clock_source_select = regs_r[ksrm_pkg::KSRM_I_PLL_LPR][ksrm_pkg::KSRM_CLOCK_SOURCE_SELECT_BIT];
	assign low_power_mode_select = regs_r[ksrm_pkg::KSRM_I_PLL_LPR][ksrm_pkg::KSRM_LPM_HI:ksrm_pkg::KSRM_LPM_LO];
	assign checkstop_reset_enable = regs_r[ksrm_pkg::KSRM_I_PLL_LPR][ksrm_pkg::KSRM_CSR_BIT];
	assign tb_write_lock = key_lock_r[ksrm_pkg::KSRM_K_TB_DEC];

endmodule : ksrm_regs
`default_nettype wire

/* include/ksrm_pkg.sv */
// register map, lock constants and decode carrier of the keyed system register bank
package ksrm_pkg;

	localparam int KSRM_AW = 24;
	localparam int KSRM_DW = 32;
	localparam int KSRM_NREG = 25;
	localparam int KSRM_NKEY = 13;

	// data register indices
	localparam logic [4:0] KSRM_I_CS3_OPT = 5'h00;
	localparam logic [4:0] KSRM_I_DMAP_BASE = 5'h01;
	localparam logic [4:0] KSRM_I_DMAP_OPT = 5'h02;
	localparam logic [4:0] KSRM_I_MEM_STAT = 5'h03;
	localparam logic [4:0] KSRM_I_TB_SC = 5'h04;
	localparam logic [4:0] KSRM_I_TB_CMP0 = 5'h05;
	localparam logic [4:0] KSRM_I_TB_CMP1 = 5'h06;
	localparam logic [4:0] KSRM_I_CAL_SC = 5'h07;
	localparam logic [4:0] KSRM_I_CAL_SEC = 5'h08;
	localparam logic [4:0] KSRM_I_ALM_RSVD = 5'h09;
	localparam logic [4:0] KSRM_I_CAL_ALM = 5'h0A;
	localparam logic [4:0] KSRM_I_PIT_SC = 5'h0B;
	localparam logic [4:0] KSRM_I_PIT_RLD = 5'h0C;
	localparam logic [4:0] KSRM_I_PIT_VAL = 5'h0D;
	localparam logic [4:0] KSRM_I_SYS_CLK = 5'h0E;
	localparam logic [4:0] KSRM_I_PLL_LPR = 5'h0F;
	localparam logic [4:0] KSRM_I_RST_CAUSE = 5'h10;
	localparam logic [4:0] KSRM_I_LOCK_CHG = 5'h11;
	localparam logic [4:0] KSRM_I_STBY_SUP = 5'h12;
	localparam logic [4:0] KSRM_I_FA_MCFG = 5'h13;
	localparam logic [4:0] KSRM_I_FB_MCFG = 5'h16;
	localparam logic [4:0] KSRM_I_NONE = 5'h19;

	// byte addresses, in index order
	localparam logic [23:0] KSRM_REG_OFS [KSRM_NREG] = '{
		24'h2FC11C, 24'h2FC140, 24'h2FC144, 24'h2FC178, 24'h2FC200,
		24'h2FC204, 24'h2FC208, 24'h2FC220, 24'h2FC224, 24'h2FC228,
		24'h2FC22C, 24'h2FC240, 24'h2FC244, 24'h2FC248, 24'h2FC280,
		24'h2FC284, 24'h2FC288, 24'h2FC28C, 24'h2FC290, 24'h2FC800,
		24'h2FC804, 24'h2FC808, 24'h2FC840, 24'h2FC844, 24'h2FC848};

	// key registers sit at their companion's address plus this step
	localparam logic [23:0] KSRM_KEY_STEP = 24'h000100;
	localparam logic [23:0] KSRM_KEY_OFS [KSRM_NKEY] = '{
		24'h2FC300, 24'h2FC304, 24'h2FC308, 24'h2FC30C, 24'h2FC320,
		24'h2FC324, 24'h2FC328, 24'h2FC32C, 24'h2FC340, 24'h2FC344,
		24'h2FC380, 24'h2FC384, 24'h2FC388};
	localparam logic [4:0] KSRM_KEY_TGT [KSRM_NKEY] = '{
		KSRM_I_TB_SC, KSRM_I_TB_CMP0, KSRM_I_TB_CMP1, KSRM_I_NONE, KSRM_I_CAL_SC,
		KSRM_I_CAL_SEC, KSRM_I_ALM_RSVD, KSRM_I_CAL_ALM, KSRM_I_PIT_SC, KSRM_I_PIT_RLD,
		KSRM_I_SYS_CLK, KSRM_I_PLL_LPR, KSRM_I_RST_CAUSE};
	localparam int KSRM_K_TB_DEC = 3;
	// calendar group comes out of power-on reset locked
	localparam logic [KSRM_NKEY-1:0] KSRM_KEY_POR_LOCK = 13'h00F0;
	localparam logic [31:0] KSRM_UNLOCK_CODE = 32'h55CCAA33;

	// per-register attributes, bit i is register i
	localparam logic [KSRM_NREG-1:0] KSRM_NARROW = 25'h0071898;
	localparam logic [KSRM_NREG-1:0] KSRM_HARD_CLR = 25'h1F8C89F;
	localparam logic [KSRM_NREG-1:0] KSRM_NOSTORE = 25'h0002200;
	localparam logic [31:0] KSRM_MASK16 = 32'h0000FFFF;
	localparam logic [31:0] KSRM_RST_VAL = 32'h00000000;

	// field positions, lsb-0 (documented bit n, msb-0, is 31-n)
	localparam int KSRM_MF_HI = 31;
	localparam int KSRM_MF_LO = 20;
	localparam int KSRM_MFL_BIT = 27;
	localparam int KSRM_LOW_POWER_MODE_LOCK_BIT = 26;
	localparam int KSRM_CLOCK_SOURCE_SELECT_BIT = 10;
	localparam int KSRM_LPM_HI = 9;
	localparam int KSRM_LPM_LO = 8;
	localparam int KSRM_CSR_BIT = 7;
	localparam int KSRM_DLK_BIT = 16;
	localparam int KSRM_KEY_LOCK_BIT = 0;

	typedef struct packed {
		logic hit;
		logic is_key;
		logic [4:0] idx;
		logic [3:0] kidx;
	} ksrm_dec_t;

endpackage : ksrm_pkg

/* tb/ksrm_regs_asserts.sv */
// bus timing and lock checks for the keyed register bank
`timescale 1ns/1ps
`default_nettype none
module ksrm_regs_asserts
(
	// clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hard_reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [23:0] paddr,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// configuration
	input wire logic [11:0] pll_multiply_factor,
	input wire logic clock_source_select,
	input wire logic [1:0] low_power_mode_select,
	input wire logic checkstop_reset_enable,
	input wire logic tb_write_lock
);
	logic cfg_wr_r;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// config outputs may only move after a pll register write or a hard reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_wr_r <= 1'h0;
		else
			cfg_wr_r <= hard_reset || (psel && penable && pready && pwrite && paddr == 24'h2FC284);
	end
	sequence s_setup(logic [23:0] a);
		psel && !penable && paddr == a;
	endsequence
	sequence s_write(logic [23:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	property p_answer;
		psel && !penable |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no ready after setup");
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready held too long");
	property p_unmapped;
		s_setup(24'h2FC120) |=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not flagged");
	property p_key_read;
		s_setup(24'h2FC30C) ##0 !pwrite |=> prdata == {31'h0, tb_write_lock};
	endproperty
	a_key_read: assert property (p_key_read) else $error("key read wrong");
	property p_unlock;
		s_write(24'h2FC30C) ##0 (pwdata == 32'h55CCAA33 && pstrb == 4'hF) |=> !tb_write_lock;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock ignored");
	property p_relock;
		s_write(24'h2FC30C) ##0 pwdata != 32'h55CCAA33 |=> tb_write_lock;
	endproperty
	a_relock: assert property (p_relock) else $error("relock ignored");
	property p_cfg_cause;
		!$stable({pll_multiply_factor, clock_source_select, low_power_mode_select,
			checkstop_reset_enable}) |-> cfg_wr_r;
	endproperty
	a_cfg_cause: assert property (p_cfg_cause) else $error("config moved alone");
	property p_hard_clear;
		hard_reset |=> {pll_multiply_factor, clock_source_select, low_power_mode_select,
			checkstop_reset_enable} == 16'h0000;
	endproperty
	a_hard_clear: assert property (p_hard_clear) else $error("hard reset kept config");
endmodule : ksrm_regs_asserts
bind ksrm_regs ksrm_regs_asserts chk_u (.*);
`default_nettype wire

/* tb/ksrm_regs_bench.sv */
// directed bench for the keyed register bank
`timescale 1ns/1ps
`default_nettype none
module ksrm_regs_bench;
	typedef struct packed {logic [23:0] a; logic [31:0] d; logic [31:0] e;} ksrm_row_t;
	logic pclk = 1'h0, presetn = 1'h0, hard_reset = 1'h0, soft_reset = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [23:0] paddr = 24'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, clock_source_select, checkstop_reset_enable, tb_write_lock;
	logic [11:0] pll_multiply_factor;
	logic [1:0] low_power_mode_select;
	logic [15:0] pit_value = 16'h1234;
	int num_errors = 0, total_checks = 0, cyc = 0;
	ksrm_row_t rows [16] = '{
		{24'h2FC178, 32'hFFFFFFFF, 32'h0000FFFF},
		{24'h2FC204, 32'h11223344, 32'h11223344},
		{24'h2FC228, 32'hFFFFFFFF, 32'h0},
		{24'h2FC248, 32'hFFFFFFFF, 32'h00001234},
		{24'h2FC120, 32'hFFFFFFFF, 32'h0},
		{24'h2FC220, 32'h1234, 32'h0},
		{24'h2FC320, 32'h55CCAA33, 32'h0},
		{24'h2FC220, 32'h1234, 32'h1234},
		{24'h2FC320, 32'h0, 32'h1},
		{24'h2FC220, 32'h5678, 32'h1234},
		{24'h2FC30C, 32'h0, 32'h1},
		{24'h2FC30C, 32'h55CCAA33, 32'h0},
		{24'h2FC284, 32'h00100780, 32'h00100780},
		{24'h2FC280, 32'h0C000000, 32'h0C000000},
		{24'h2FC280, 32'h0, 32'h0C000000},
		{24'h2FC284, 32'hFFF00000, 32'h00100780}};
	always #20 pclk = ~pclk;
	ksrm_regs dut_u (.*);
	task automatic xfer(input logic [23:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrc(input logic [23:0] a, input logic [31:0] d, input logic [31:0] e);
		xfer(a, 1'h1, d);
		xfer(a, 1'h0, 32'h0);
		chk(rd, e);
	endtask : wrc
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			finish_test;
		end
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i])
			wrc(rows[i].a, rows[i].d, rows[i].e);
		$display("table done");
		wrc(24'h2FC384, 32'h0, 32'h1);
		soft_reset <= 1'h1;
		@(posedge pclk);
		soft_reset <= 1'h0;
		wrc(24'h2FC284, 32'h0, 32'h00100780);
		wrc(24'h2FC384, 32'h55CCAA33, 32'h0);
		wrc(24'h2FC284, 32'h0, 32'h00100700);
		wrc(24'h2FC284, 32'h80, 32'h00100700);
		chk(32'({pll_multiply_factor, clock_source_select, low_power_mode_select,
			checkstop_reset_enable}), 32'h001E);
		$display("soft reset done");
		hard_reset <= 1'h1;
		@(posedge pclk);
		hard_reset <= 1'h0;
		wrc(24'h2FC800, 32'h5, 32'h5);
		wrc(24'h2FC204, 32'h11223344, 32'h11223344);
		wrc(24'h2FC280, 32'h04000000, 32'h0);
		$display("hard reset done");
		presetn <= 1'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		wrc(24'h2FC220, 32'h1, 32'h0);
		wrc(24'h2FC280, 32'h04000000, 32'h04000000);
		$display("power-on reset done");
		finish_test;
	end
endmodule : ksrm_regs_bench
`default_nettype wire
